// File: rtl/lsic_pkg.sv
// Purpose : Shared constants for the light sensor interrupt controller.
// Assumes : 40 MHz core clock; 8-bit register bus from the serial slave.
// Notes   : Reset values of all control state are zero.
`default_nettype none
package lsic_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam logic [7:0]  REG_INT_CTRL    = 8'h02;
   localparam logic [7:0]  REG_INT_SRC     = 8'h03;
   localparam logic [7:0]  INT_CTRL_RST    = 8'h00;
   localparam logic [7:0]  INT_SRC_RST     = 8'h00;
   localparam int unsigned HALT_BIT        = 6;
   localparam int unsigned MODE_HI         = 5;
   localparam int unsigned MODE_LO         = 4;
   localparam int unsigned PERS_HI         = 2;
   localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0C;
   localparam logic [6:0]  OWN_ADDR        = 7'h39;
   localparam logic [1:0]  CLEAR_ACTION    = 2'h3;
   localparam logic [1:0]  MODE_OFF        = 2'h0;
   localparam logic [1:0]  MODE_LEVEL      = 2'h1;
   localparam logic [1:0]  MODE_ALERT      = 2'h2;
   localparam logic [1:0]  MODE_FORCE      = 2'h3;
   localparam logic [2:0]  PERS_EVERY      = 3'h0;
   localparam logic [2:0]  PERS_SINGLE     = 3'h1;
   localparam logic [2:0]  PERS_100MS      = 3'h2;
   localparam logic [2:0]  PERS_1S         = 3'h3;
   localparam int unsigned T_100MS_MS      = 100;
   localparam int unsigned T_1S_MS         = 1000;
   localparam int unsigned CYC_100MS       = CLK_HZ / 1000 * T_100MS_MS;
   localparam int unsigned CYC_1S          = CLK_HZ / 1000 * T_1S_MS;
   localparam int unsigned TICK_DIV        = 40_000;
endpackage : lsic_pkg
`default_nettype wire

// File: rtl/lsic_persist.sv
// Purpose : Persistence filter for an out-of-window condition.
// Assumes : A millisecond enable pulse and a per-conversion strobe.
// Notes   : Any in-range result restarts the time accumulation.
`default_nettype none
module lsic_persist
   import lsic_pkg::*;
#(
   parameter int unsigned CNT_W = 11
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ms_tick_i,
   input  wire logic       conv_i,
   input  wire logic       out_i,
   input  wire logic [2:0] pers_i,
   input  wire logic [CNT_W-1:0] ms_100_i,
   input  wire logic [CNT_W-1:0] ms_1s_i,
   output logic            fire_o
);
   logic [CNT_W-1:0] ms_r;
   logic             out_r;
   logic             done_r;
   wire  [CNT_W-1:0] limit = (pers_i == PERS_1S) ? ms_1s_i : ms_100_i;
   wire              timed = (pers_i == PERS_100MS) || (pers_i == PERS_1S);
   wire              reach = out_r && !done_r && ms_tick_i && (ms_r + 1'b1 >= limit);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ms_r   <= '0;
         out_r  <= 1'b0;
         done_r <= 1'b0;
      end else begin
         if (conv_i) begin
            out_r <= out_i;
            if (!out_i) begin
               ms_r   <= '0;
               done_r <= 1'b0;
            end
         end else if (timed && reach) begin
            done_r <= 1'b1;
         end else if (out_r && ms_tick_i && !done_r) begin
            ms_r <= ms_r + 1'b1;
         end
      end
   end

   assign fire_o = (pers_i == PERS_EVERY) ? conv_i :
                   timed ? reach : (conv_i && out_i);
endmodule : lsic_persist
`default_nettype wire

// File: rtl/lsic_top.sv
// Purpose : Interrupt generation and clearing for a four-channel light sensor.
// Assumes : The serial slave decodes bus traffic into strobes on clk_i.
// Notes   : Open-drain pin is modelled as drive-low output and its enable.
`default_nettype none
module lsic_top
   import lsic_pkg::*;
#(
   parameter int unsigned DATA_W    = 16,
   parameter int unsigned TICK_CYC  = TICK_DIV,
   parameter int unsigned MS_100    = T_100MS_MS,
   parameter int unsigned MS_1S     = T_1S_MS
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              reg_wr_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   input  wire logic              cmd_wr_i,
   input  wire logic [1:0]        cmd_action_i,
   input  wire logic              ara_rd_i,
   input  wire logic [6:0]        ara_addr_i,
   input  wire logic              ara_lost_i,
   output logic      [7:0]        ara_data_o,
   output logic                   ara_hit_o,
   input  wire logic              conv_done_i,
   input  wire logic [DATA_W-1:0] green_i,
   input  wire logic [DATA_W-1:0] red_i,
   input  wire logic [DATA_W-1:0] blue_i,
   input  wire logic [DATA_W-1:0] clear_i,
   input  wire logic [DATA_W-1:0] thr_low_i,
   input  wire logic [DATA_W-1:0] thr_high_i,
   input  wire logic              irq_pin_i,
   output logic                   irq_o,
   output logic                   irq_oe_o,
   output logic                   halt_integ_o,
   output logic                   irq_pending_o
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [1:0]  src_r;
   logic        pend_r;
   logic        alert_r;
   logic        force_r;
   logic [15:0] tick_cnt_r;
   logic        ms_tick_r;
   logic [1:0]  pin_sync_r;
   logic [7:0]  rdata_r;
   logic [7:0]  ara_data_r;
   logic        ara_hit_r;

   wire         wr_ctrl     = reg_wr_i && (reg_addr_i == REG_INT_CTRL);
   wire         wr_src      = reg_wr_i && (reg_addr_i == REG_INT_SRC);
   wire [1:0]   mode        = ctrl_r[MODE_HI:MODE_LO];
   wire [2:0]   pers        = ctrl_r[PERS_HI:0];
   wire         halt_en     = ctrl_r[HALT_BIT];
   wire [7:0]   ctrl_wmask  = 8'h77;

   // ------------------------------------------------------------
   // Source select and window compare
   // ------------------------------------------------------------
   logic [DATA_W-1:0] sel_val;
   always_comb begin
      case (src_r)
         2'h0:    sel_val = green_i;
         2'h1:    sel_val = red_i;
         2'h2:    sel_val = blue_i;
         default: sel_val = clear_i;
      endcase
   end
   wire outside = (sel_val < thr_low_i) || (sel_val > thr_high_i);

   // ------------------------------------------------------------
   // Millisecond enable
   // ------------------------------------------------------------
   wire tick_wrap = (tick_cnt_r == 16'(TICK_CYC - 1));
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_r <= 16'h0000;
         ms_tick_r  <= 1'b0;
      end else begin
         tick_cnt_r <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
         ms_tick_r  <= tick_wrap;
      end
   end

   logic fire;
   lsic_persist #(
      .CNT_W (11)
   ) u_persist (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ms_tick_i (ms_tick_r),
      .conv_i    (conv_done_i),
      .out_i     (outside),
      .pers_i    (pers),
      .ms_100_i  (11'(MS_100)),
      .ms_1s_i   (11'(MS_1S)),
      .fire_o    (fire)
   );

   // ------------------------------------------------------------
   // Pending state, set and clear
   // ------------------------------------------------------------
   wire alert_like  = (mode == MODE_ALERT) || (mode == MODE_FORCE);
   wire set_thr     = fire && (mode != MODE_OFF);
   wire set_force   = wr_ctrl && (reg_wdata_i[MODE_HI:MODE_LO] == MODE_FORCE);
   wire ara_match   = ara_rd_i && (ara_addr_i == ALERT_RESP_ADDR);
   wire ara_clear   = ara_match && pend_r && alert_like && !ara_lost_i;
   wire cmd_clear   = cmd_wr_i && (cmd_action_i == CLEAR_ACTION) &&
                      (mode == MODE_LEVEL);
   wire set_any     = set_thr || set_force;
   wire pend_nxt    = set_any ? 1'b1 : ((cmd_clear || ara_clear) ? 1'b0 : pend_r);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= INT_CTRL_RST;
         src_r  <= INT_SRC_RST[1:0];
      end else begin
         if (wr_ctrl) ctrl_r <= reg_wdata_i & ctrl_wmask;
         if (wr_src)  src_r  <= reg_wdata_i[1:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r  <= 1'b0;
         force_r <= 1'b0;
      end else begin
         pend_r  <= pend_nxt;
         force_r <= set_force;
      end
   end

   // ------------------------------------------------------------
   // Alert response and read data
   // ------------------------------------------------------------
   wire [7:0] rsel = (reg_addr_i == REG_INT_CTRL) ? ctrl_r :
                     (reg_addr_i == REG_INT_SRC)  ? {6'h00, src_r} : 8'h00;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r    <= 8'h00;
         ara_data_r <= 8'h00;
         ara_hit_r  <= 1'b0;
         alert_r    <= 1'b0;
         pin_sync_r <= 2'b11;
      end else begin
         rdata_r    <= rsel;
         ara_hit_r  <= ara_clear;
         if (ara_clear)
            ara_data_r <= {OWN_ADDR, 1'b0};
         alert_r    <= pend_nxt && (mode != MODE_OFF);
         pin_sync_r <= {pin_sync_r[0], irq_pin_i};
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata_o   = rdata_r;
   assign ara_data_o    = ara_data_r;
   assign ara_hit_o     = ara_hit_r;
   assign irq_o         = 1'b0;
   assign irq_oe_o      = alert_r;
   assign irq_pending_o = alert_r;

   // ------------------------------------------------------------
   // Integration halt
   // ------------------------------------------------------------
   // Halt follows the asserted line; the host resumes with a clear alone, which drops halt with the line.
   logic halt_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) halt_r <= 1'b0;
      else       halt_r <= halt_en && pend_nxt && (mode != MODE_OFF);
   end
   assign halt_integ_o = halt_r;

   // ------------------------------------------------------------
   // Checks on the pending state
   // ------------------------------------------------------------
   // These watch only what this block drives; another device holding the
   // shared line low is legal and must never trip them.
   pend_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pend_r && !cmd_clear && !ara_clear) |=> pend_r)
      else $error("pending interrupt dropped without a clear");

   set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      set_any |=> pend_r)
      else $error("interrupt set was lost");

   thr_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done_i && outside && (pers == PERS_SINGLE) && (mode == MODE_LEVEL)) |=> pend_r)
      else $error("out of window result did not set the interrupt");

   in_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done_i && !outside && (pers == PERS_SINGLE) && !pend_r && !set_force)
      |=> !pend_r)
      else $error("in range result set the interrupt");

   every_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done_i && (pers == PERS_EVERY) && (mode != MODE_OFF)) |=> pend_r)
      else $error("every cycle persistence did not set the interrupt");

   off_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((mode == MODE_OFF) && !set_force && !pend_r) |=> !pend_r)
      else $error("interrupt set while disabled");

   level_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cmd_clear && !set_any) |=> !irq_oe_o)
      else $error("level clear did not release the pin");

   // ------------------------------------------------------------
   // Checks on the pin
   // ------------------------------------------------------------
   force_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (force_r && !ara_clear) |=> irq_oe_o)
      else $error("forced interrupt did not drive the pin");

   mode_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((mode == MODE_OFF) && !set_force) |=> !irq_oe_o)
      else $error("pin driven while interrupt disabled");

   level_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (set_thr && (mode == MODE_LEVEL)) |=> irq_oe_o)
      else $error("level interrupt did not drive the pin");

   alert_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pend_r && alert_like && !ara_clear) |=> irq_oe_o)
      else $error("alert line released without a response");

   pin_echo_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(irq_oe_o, 2) |-> !pin_sync_r[1])
      else $error("driven pin did not read back low");

   // ------------------------------------------------------------
   // Checks on the alert response
   // ------------------------------------------------------------
   lost_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pend_r && ara_match && ara_lost_i && !cmd_clear) |=> pend_r)
      else $error("arbitration loss cleared the interrupt");

   ara_reply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ara_clear |=> ((ara_data_o == {OWN_ADDR, 1'b0}) && ara_hit_o))
      else $error("alert response byte wrong");

   ara_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ara_rd_i && (ara_addr_i != ALERT_RESP_ADDR)) |=> !ara_hit_o)
      else $error("answered a receive byte to another address");

   ara_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ara_rd_i && (mode == MODE_LEVEL)) |=> !ara_hit_o)
      else $error("answered an alert response in level mode");

   ara_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ara_rd_i && !pend_r) |=> !ara_hit_o)
      else $error("answered an alert response with nothing pending");

   // ------------------------------------------------------------
   // Checks on halt, control and timing
   // ------------------------------------------------------------
   halt_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
      halt_integ_o |-> (irq_oe_o && $past(halt_en)))
      else $error("halt without asserted interrupt");

   halt_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !halt_en |=> !halt_integ_o)
      else $error("halt raised with the halt bit clear");

   halt_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (halt_en && pend_r && (mode != MODE_OFF) && !cmd_clear && !ara_clear)
      |=> halt_integ_o)
      else $error("asserted interrupt did not halt integration");

   ctrl_rsv_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ctrl |=> ((ctrl_r[7] == 1'b0) && (ctrl_r[3] == 1'b0)))
      else $error("reserved control bit stored");

   tick_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ms_tick_r |=> !ms_tick_r)
      else $error("millisecond enable wider than one cycle");

endmodule : lsic_top
`default_nettype wire

// File: bench/lsic_host.sv
// Purpose : Host side of the open-drain interrupt wire.
// Assumes : A pull-up on the wire; the host services a low wire.
// Notes   : A released wire reads high, never a held value.
`default_nettype none
module lsic_host (
   input  wire logic irq_i,
   input  wire logic irq_oe_i,
   output logic      pin_o,
   output logic      alert_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // The pull-up wins whenever the device lets go of the wire.
   assign pin_o   = irq_oe_i ? irq_i : 1'b1;
   // A low wire asks for service: a clear command or an alert response,
   // and that clear alone also lifts any integration halt.
   assign alert_o = ~pin_o;
endmodule // lsic_host
`default_nettype wire

// File: bench/tb_lsic_top.sv
// Purpose : Self-checking bench for the interrupt controller.
// Assumes : Short millisecond tick so the timed filters finish quickly.
// Notes   : A small model of the pending flag is kept beside the design.
`default_nettype none
module tb_lsic_top
   import lsic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, rst = 1, wr = 0, cw = 0, ar = 0, lost = 0, cv = 0, mp = 0;
   logic [7:0]  addr = '0, wd = '0;
   logic [1:0]  act = '0;
   logic [6:0]  aa = '0;
   logic [15:0] ch [4];
   logic [15:0] lo = 16'h03E8, hi = 16'h1388, seed = 16'hC9CA;
   wire  [7:0]  rd, ad;
   wire         hit, irq, oe, halt, pend, pin, alert;
   int          error_cnt = 0, tests_run = 0, src = 0;
   lsic_top #(.TICK_CYC(4), .MS_100(5), .MS_1S(12)) u_dut (
      .clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_rdata_o(rd), .cmd_wr_i(cw), .cmd_action_i(act), .ara_rd_i(ar),
      .ara_addr_i(aa), .ara_lost_i(lost), .ara_data_o(ad), .ara_hit_o(hit),
      .conv_done_i(cv), .green_i(ch[0]), .red_i(ch[1]), .blue_i(ch[2]),
      .clear_i(ch[3]), .thr_low_i(lo), .thr_high_i(hi), .irq_pin_i(pin),
      .irq_o(irq), .irq_oe_o(oe), .halt_integ_o(halt), .irq_pending_o(pend));
   lsic_host u_host (.irq_i(irq), .irq_oe_i(oe), .pin_o(pin), .alert_o(alert));
   initial begin
      forever #12.5 clk = ~clk;
   end
   //------------------------------------------------------------------
   // Stimulus and checks
   //------------------------------------------------------------------
   function automatic logic [15:0] rnd();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed;
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stp();
      @(posedge clk);
      #2;
   endtask
   task automatic wt(input int n);
      repeat (n) stp();
   endtask
   task automatic pchk();
      chk(pend, mp);
      chk(oe, mp);
      chk(pin, !mp);
      chk(alert, mp);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1;
      stp();
      wr = 0;
      stp();
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      stp();
      chk(rd, e);
   endtask
   task automatic cmd(input logic [1:0] a);
      act = a;
      cw = 1;
      stp();
      cw = 0;
      stp();
   endtask
   task automatic ara(input logic [6:0] a, input logic l, input logic h);
      aa = a;
      lost = l;
      ar = 1;
      stp();
      ar = 0;
      lost = 0;
      chk(hit, h);
      if (h) chk(ad, {OWN_ADDR, 1'b0});
      if (h) mp = 0;
      stp();
   endtask
   task automatic conv(input logic [15:0] v);
      for (int i = 0; i < 4; i++) ch[i] = rnd();
      ch[src] = v;
      cv = 1;
      stp();
      cv = 0;
      stp();
   endtask
   initial begin
      for (int i = 0; i < 4; i++) ch[i] = '0;
      #500000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      #2 rst = 0;
      stp();
      rreg(REG_INT_CTRL, 8'h00);
      rreg(REG_INT_SRC, 8'h00);
      rreg(8'h05, 8'h00);
      pchk();
      $display("test reset finished");
      wreg(REG_INT_CTRL, 8'hFF);
      mp = 1;
      pchk();
      chk(halt, 1'b1);
      rreg(REG_INT_CTRL, 8'h77);
      cmd(2'h3);
      pchk();
      ara(7'h0D, 1'b0, 1'b0);
      ara(ALERT_RESP_ADDR, 1'b1, 1'b0);
      pchk();
      ara(ALERT_RESP_ADDR, 1'b0, 1'b1);
      pchk();
      $display("test forced interrupt finished");
      for (int i = 0; i < 4; i++) begin
         src = i;
         wreg(REG_INT_SRC, 8'(i));
         wreg(REG_INT_CTRL, 8'h11);
         conv(lo);
         conv(hi);
         pchk();
         conv(i[0] ? lo - 16'h0001 : hi + 16'h0001 + (rnd() & 16'h0FFF));
         mp = 1;
         pchk();
         chk(halt, 1'b0);
         cmd(2'h1);
         ara(ALERT_RESP_ADDR, 1'b0, 1'b0);
         pchk();
         cmd(CLEAR_ACTION);
         mp = 0;
         pchk();
      end
      $display("test level mode finished");
      wreg(REG_INT_CTRL, 8'h20);
      conv(lo + 16'h0010);
      mp = 1;
      pchk();
      ara(ALERT_RESP_ADDR, 1'b0, 1'b1);
      wreg(REG_INT_CTRL, 8'h01);
      conv(hi + 16'h0100);
      pchk();
      $display("test alert and off finished");
      wreg(REG_INT_CTRL, 8'h12);
      conv(hi + 16'h0001);
      wt(8);
      conv(lo);
      conv(hi + 16'h0001);
      wt(8);
      pchk();
      wt(24);
      mp = 1;
      pchk();
      cmd(CLEAR_ACTION);
      mp = 0;
      wreg(REG_INT_CTRL, 8'h13);
      conv(lo);
      conv(lo - 16'h0001);
      wt(32);
      pchk();
      wt(32);
      mp = 1;
      pchk();
      $display("test persistence finished");
      wreg(REG_INT_CTRL, 8'h53);
      chk(halt, 1'b1);
      cmd(CLEAR_ACTION);
      mp = 0;
      chk(halt, 1'b0);
      pchk();
      $display("test halt resume finished");
      give_verdict();
   end
endmodule // tb_lsic_top
`default_nettype wire
